// ==== design/qdc_consts.vh ====
// constants for the quad dac command interpreter
`ifndef QDC_CONSTS_VH
`define QDC_CONSTS_VH
`define QDC_FRAME_BITS      6'd32
`define QDC_CMD_HI          27
`define QDC_CMD_LO          24
`define QDC_ADDR_HI         23
`define QDC_ADDR_LO         20
`define QDC_DATA_HI         19
`define QDC_DATA_LO         4
`define QDC_PD_HI           9
`define QDC_PD_LO           8
`define QDC_CMD_WR_IN       4'h0
`define QDC_CMD_UPD_DAC     4'h1
`define QDC_CMD_WR_IN_ALL   4'h2
`define QDC_CMD_WR_UPD_ONE  4'h3
`define QDC_CMD_POWER       4'h4
`define QDC_CMD_CLR_CODE    4'h5
`define QDC_CMD_LOAD_MASK   4'h6
`define QDC_CMD_SETUP       4'h8
`define QDC_ADDR_ALL        4'hf
`define QDC_CLR_ZERO        2'h0
`define QDC_CLR_MID         2'h1
`define QDC_CLR_FULL        2'h2
`define QDC_CLR_NOP         2'h3
`define QDC_CODE_ZERO       16'h0000
`define QDC_CODE_MID        16'h8000
`define QDC_CODE_FULL       16'hffff
`define QDC_MASK_RESET      4'h0
`define QDC_SETUP_RESET     2'h0
`define QDC_PD_NORMAL       2'h0
`define QDC_SYNC_WARM       2'h3
`endif

// ==== design/qdc_edge_sync.v ====
// two-flop synchroniser with falling and rising edge pulses
`timescale 1ns/1ns
`include "qdc_consts.vh"
module qdc_edge_sync (
    input  wire clk_in,
    input  wire reset_n_in,
    input  wire async_in,
    output wire level_out,
    output wire fall_out,
    output wire rise_out
);
    reg       meta_reg;
    reg       sync_reg;
    reg       last_reg;
    reg [1:0] warm_reg;
    wire      warm_done;

    // resets high: idle level of all active-low pins here
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
            last_reg <= 1'b1;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    // edges held off until last_reg holds the real pin level, so a pin
    // that idles low gives no false fall right after reset
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in)
            warm_reg <= 2'h0;
        else if (warm_reg != `QDC_SYNC_WARM)
            warm_reg <= warm_reg + 2'h1;
    end

    assign warm_done = (warm_reg == `QDC_SYNC_WARM);
    assign level_out = sync_reg;
    assign fall_out  = warm_done & last_reg & ~sync_reg;
    assign rise_out  = warm_done & ~last_reg & sync_reg;
endmodule

// ==== design/qdc_core.v ====
// serial frame decoder, input/dac registers, clear and load control
`timescale 1ns/1ns
`include "qdc_consts.vh"

// Summary of operation
// - clear pin synchronised to system clock, independent of shift clock
// - clear acts only on falling edge of clear pin
// - clear loads all input and dac registers with selected code
// - clear selection is two bits taken from frame bits 1 and 0
// - clear selection resets to zero scale
// - command 0101 writes clear selection
// - cleared state ends when next valid frame completes
// - clear during a frame aborts that frame
// - load pin low: addressed dac register updates at frame end
// - load pin high, no override: dac register unchanged by write
// - load pin falling edge copies pin-controlled channels together
// - command 0011 writes input register then updates all dacs
// - override bit 1 updates channel at frame end, 0 follows pin
// - command 0110 writes four-bit override mask, bit3 is d
// - override mask resets to zero
// - power mode 00 normal, 01 1k, 10 100k, 11 three-state
// - command 0100 sets mode for channels chosen by bits 3..0
// - command 1000 writes chain enable bit1, reference bit0
// - frame acts at every 32nd falling shift edge (32nd, 64th, ...), select low
// - select high early discards frame with no change
// - chain and reference bits default to zero
// - selection 00,01,10 give 0000,8000,ffff; 11 no change
module qdc_core (
    input  wire          clk_in,
    input  wire          reset_n_in,
    input  wire          shift_clk_in,
    input  wire          frame_sel_n_in,
    input  wire          serial_data_in,
    input  wire          async_clear_pin_n_in,
    input  wire          load_outputs_pin_n_in,
    output reg  [63:0]   dac_codes_out,
    output reg  [63:0]   input_codes_out,
    output reg  [7:0]    outload_sel_out,
    output reg  [3:0]    load_override_mask_out,
    output reg  [1:0]    clear_code_select_out,
    output reg           chain_enable_out,
    output reg           reference_on_out,
    output reg           cleared_out,
    output reg           serial_out
);
    wire sclk_lvl;
    wire sclk_fall;
    wire sclk_rise;
    wire sel_lvl;
    wire sel_fall;
    wire sel_rise;
    wire clr_lvl;
    wire clr_fall;
    wire clr_rise;
    wire ld_lvl;
    wire ld_fall;
    wire ld_rise;
    wire din_lvl;

    // every pin passes two flops before any logic reads it
    qdc_edge_sync u_sclk (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .async_in   (shift_clk_in),
        .level_out  (sclk_lvl),
        .fall_out   (sclk_fall),
        .rise_out   (sclk_rise)
    );
    qdc_edge_sync u_sel (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .async_in   (frame_sel_n_in),
        .level_out  (sel_lvl),
        .fall_out   (sel_fall),
        .rise_out   (sel_rise)
    );
    qdc_edge_sync u_clr (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .async_in   (async_clear_pin_n_in),
        .level_out  (clr_lvl),
        .fall_out   (clr_fall),
        .rise_out   (clr_rise)
    );
    qdc_edge_sync u_ld (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .async_in   (load_outputs_pin_n_in),
        .level_out  (ld_lvl),
        .fall_out   (ld_fall),
        .rise_out   (ld_rise)
    );
    // data pin shares the synchroniser; its edge pulses are unused
    qdc_edge_sync u_din (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .async_in   (serial_data_in),
        .level_out  (din_lvl),
        .fall_out   (),
        .rise_out   ()
    );

    // decode of the clear selection into a code
    function [15:0] clear_code;
        input [1:0] sel;
        begin
            case (sel)
                `QDC_CLR_MID:  clear_code = `QDC_CODE_MID;
                `QDC_CLR_FULL: clear_code = `QDC_CODE_FULL;
                default:       clear_code = `QDC_CODE_ZERO;
            endcase
        end
    endfunction

    // channel address decode, used for input and dac writes
    function [3:0] chan_hit;
        input [3:0] addr;
        begin
            if (addr == `QDC_ADDR_ALL)
                chan_hit = 4'hf;
            else if (addr[3:2] == 2'b00)
                chan_hit = 4'h1 << addr[1:0];
            else
                chan_hit = 4'h0;
        end
    endfunction

    reg  [31:0] shift_reg;
    reg  [5:0]  count_reg;
    reg         abort_reg;

    // frame word as it stands after the 32nd bit is shifted in
    wire [31:0] word = {shift_reg[30:0], din_lvl};
    wire        frame_done = sclk_fall & ~sel_lvl & ~abort_reg
                             & (count_reg == `QDC_FRAME_BITS - 6'd1);
    wire [3:0]  cmd  = word[`QDC_CMD_HI:`QDC_CMD_LO];
    wire [3:0]  hit  = chan_hit(word[`QDC_ADDR_HI:`QDC_ADDR_LO]);
    wire [15:0] data = word[`QDC_DATA_HI:`QDC_DATA_LO];
    // 0010 and 0011 both write the addressed input(s) and then update every dac
    wire        upd_all = (cmd == `QDC_CMD_WR_IN_ALL)
                          | (cmd == `QDC_CMD_WR_UPD_ONE);

    // shifter: counts falling edges while select is low
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            shift_reg <= 32'h0000_0000;
            count_reg <= 6'h00;
            abort_reg <= 1'b0;
        end else if (sel_lvl) begin
            shift_reg <= 32'h0000_0000;
            count_reg <= 6'h00;
            abort_reg <= 1'b0;
        end else if (clr_fall) begin
            abort_reg <= 1'b1;
        end else if (sclk_fall) begin
            shift_reg <= word;
            if (count_reg == `QDC_FRAME_BITS - 6'd1)
                count_reg <= 6'h00;     // wraps to 0: each further 32 bits act as another frame
            else
                count_reg <= count_reg + 6'd1;
        end
    end

    // chain output: bit shifted out on the rising shift edge
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in)
            serial_out <= 1'b0;
        else if (sclk_rise & ~sel_lvl & chain_enable_out)
            serial_out <= shift_reg[31];
    end

    // per-channel update and register writes
    integer ch;
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            dac_codes_out          <= {64{1'b0}};
            input_codes_out        <= {64{1'b0}};
            outload_sel_out        <= 8'h00;
            load_override_mask_out <= `QDC_MASK_RESET;
            clear_code_select_out  <= `QDC_CLR_ZERO;
            chain_enable_out       <= 1'b0;
            reference_on_out       <= 1'b0;
            cleared_out            <= 1'b0;
        end else if (clr_fall) begin
            // clear wins over a frame ending in the same cycle
            for (ch = 0; ch < 4; ch = ch + 1) begin
                input_codes_out[ch*16 +: 16] <=
                    clear_code(clear_code_select_out);
                dac_codes_out[ch*16 +: 16]   <=
                    clear_code(clear_code_select_out);
            end
            cleared_out <= 1'b1;
        end else if (frame_done) begin
            cleared_out <= 1'b0;
            case (cmd)
                `QDC_CMD_WR_IN,
                `QDC_CMD_WR_IN_ALL,
                `QDC_CMD_WR_UPD_ONE: begin
                    for (ch = 0; ch < 4; ch = ch + 1) begin
                        if (hit[ch]) begin
                            input_codes_out[ch*16 +: 16] <= data;
                            // 0010/0011, pin low or override: immediate
                            if (upd_all || ~ld_lvl
                                || load_override_mask_out[ch])
                                dac_codes_out[ch*16 +: 16]
                                    <= data;
                        end else if (upd_all)
                            dac_codes_out[ch*16 +: 16]
                                <= input_codes_out[ch*16 +: 16];
                    end
                end
                `QDC_CMD_UPD_DAC: begin
                    for (ch = 0; ch < 4; ch = ch + 1)
                        if (hit[ch])
                            dac_codes_out[ch*16 +: 16]
                                <= input_codes_out[ch*16 +: 16];
                end
                `QDC_CMD_POWER: begin
                    for (ch = 0; ch < 4; ch = ch + 1)
                        if (word[ch])
                            outload_sel_out[ch*2 +: 2]
                                <= word[`QDC_PD_HI:`QDC_PD_LO];
                end
                `QDC_CMD_CLR_CODE: begin
                    if (word[1:0] != `QDC_CLR_NOP)
                        clear_code_select_out <= word[1:0];
                end
                `QDC_CMD_LOAD_MASK:
                    load_override_mask_out <= word[3:0];
                `QDC_CMD_SETUP: begin
                    chain_enable_out <= word[1];
                    reference_on_out <= word[0];
                end
                default: ;
            endcase
        end else if (ld_fall) begin
            for (ch = 0; ch < 4; ch = ch + 1)
                if (~load_override_mask_out[ch])
                    dac_codes_out[ch*16 +: 16]
                        <= input_codes_out[ch*16 +: 16];
        end
    end
endmodule

// ==== verif/qdc_host_model.sv ====
// host side model driving frames on the three-wire link
`timescale 1ns/1ns
module qdc_host_model (
    output logic shift_clk_out,
    output logic frame_sel_n_out,
    output logic serial_data_out
);
    // link idles with clock high and select released
    initial begin
        shift_clk_out = 1'b1;
        frame_sel_n_out = 1'b1;
        serial_data_out = 1'b0;
    end
    // msb first, 125 ns per bit; clock stands still between frames
    task automatic send(input logic [31:0] w, input int n);
        #1 frame_sel_n_out = 1'b0;
        for (int i = 31; i > 31 - n; i--) begin
            serial_data_out = w[i];
            #62 shift_clk_out = 1'b0;
            #63 shift_clk_out = 1'b1;
        end
        #63 frame_sel_n_out = 1'b1;
        // released line must not keep showing the last bit
        serial_data_out = ~serial_data_out;
    endtask
endmodule

// ==== verif/qdc_core_chk.sv ====
// port-level assertions for the command interpreter
`timescale 1ns/1ns
module qdc_core_chk (
    input wire logic        clk_in,
    input wire logic        reset_n_in,
    input wire logic        frame_sel_n_in,
    input wire logic        async_clear_pin_n_in,
    input wire logic        load_outputs_pin_n_in,
    input wire logic [63:0] dac_codes_out,
    input wire logic [63:0] input_codes_out,
    input wire logic [7:0]  outload_sel_out,
    input wire logic [3:0]  load_override_mask_out,
    input wire logic [1:0]  clear_code_select_out,
    input wire logic        chain_enable_out,
    input wire logic        reference_on_out,
    input wire logic        cleared_out
);
    logic [15:0] clr_val;
    logic [15:0] cfg;
    // code a clear must leave; all settings gathered in one word
    assign clr_val = (clear_code_select_out == 2'h0) ? 16'h0000 :
                     (clear_code_select_out == 2'h1) ? 16'h8000 : 16'hffff;
    assign cfg = {load_override_mask_out, clear_code_select_out,
                  chain_enable_out, reference_on_out, outload_sel_out};
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    property p_clr_set; $fell(async_clear_pin_n_in) |-> ##[1:8] cleared_out;
    endproperty
    a_clr_set: assert property (p_clr_set) else $error("no clear");
    property p_clr_val; $rose(cleared_out) |-> ##2 (dac_codes_out ==
        {4{clr_val}} && input_codes_out == {4{clr_val}}); endproperty
    a_clr_val: assert property (p_clr_val) else $error("clear code");
    property p_clr_cause; $rose(cleared_out) |-> !async_clear_pin_n_in;
    endproperty
    a_clr_cause: assert property (p_clr_cause) else $error("clr");
    property p_clr_exit; $fell(cleared_out) |-> !frame_sel_n_in; endproperty
    a_clr_exit: assert property (p_clr_exit) else $error("exit");
    property p_sel_ok; clear_code_select_out != 2'h3; endproperty
    a_sel_ok: assert property (p_sel_ok) else $error("sel 11");
    property p_cfg_hold; frame_sel_n_in [*8] |-> $stable(cfg); endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("cfg");
    property p_load; $fell(load_outputs_pin_n_in) |-> ##[3:8]
        (dac_codes_out == input_codes_out); endproperty
    a_load: assert property (p_load) else $error("load edge");
    property p_rst; $rose(reset_n_in) |-> (cfg == 16'h0000 && !cleared_out);
    endproperty
    a_rst: assert property (p_rst) else $error("reset");
endmodule
bind qdc_core qdc_core_chk qdc_core_chk_inst (.*);

// ==== verif/tb.sv ====
// self-checking bench: random frames, pin edges and aborts
`timescale 1ns/1ns
module tb;
    logic        clk_in = 1'b0;
    logic        reset_n_in = 1'b0;
    logic        clr_n = 1'b1;
    logic        ld_n = 1'b0;
    wire  [63:0] dac, inp;
    wire  [7:0]  pd;
    wire  [3:0]  mask;
    wire  [1:0]  sel;
    wire         chain, refon, clrd, sclk, sync_n, din, so;
    logic [15:0] e_in [4] = '{default: 16'h0000};
    logic [15:0] e_dac [4] = '{default: 16'h0000};
    logic [7:0]  e_pd = 8'h00;
    logic [3:0]  e_mask = 4'h0;
    logic [1:0]  e_sel = 2'h0;
    logic        e_ch = 1'b0, e_ref = 1'b0, e_clr = 1'b0;
    int          num_errors = 0, total_checks = 0;
    // 100 MHz system clock
    initial forever #5 clk_in = ~clk_in;
    qdc_host_model qdc_host_model_inst (.shift_clk_out(sclk),
        .frame_sel_n_out(sync_n), .serial_data_out(din));
    qdc_core qdc_core_inst (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .shift_clk_in(sclk), .frame_sel_n_in(sync_n), .serial_data_in(din),
        .async_clear_pin_n_in(clr_n), .load_outputs_pin_n_in(ld_n),
        .dac_codes_out(dac), .input_codes_out(inp), .outload_sel_out(pd),
        .load_override_mask_out(mask), .clear_code_select_out(sel),
        .chain_enable_out(chain), .reference_on_out(refon),
        .cleared_out(clrd), .serial_out(so));
    function automatic logic [15:0] code(input logic [1:0] s);
        return (s == 2'h0) ? 16'h0000 : (s == 2'h1) ? 16'h8000 : 16'hffff;
    endfunction
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic settle();
        repeat (12) @(posedge clk_in);
        check(dac, {e_dac[3], e_dac[2], e_dac[1], e_dac[0]});
        check(inp, {e_in[3], e_in[2], e_in[1], e_in[0]});
        check(64'(pd), 64'(e_pd));
        check(64'(mask), 64'(e_mask));
        check(64'({sel, chain, refon, clrd}),
              64'({e_sel, e_ch, e_ref, e_clr}));
    endtask
    // reference model of one completed frame
    task automatic predict(input logic [31:0] w);
        logic [3:0] h;
        // address 1111 hits all channels, 00xx one, anything else none
        h = (w[23:20] == 4'hf) ? 4'hf :
            (w[23:22] == 2'b00) ? 4'h1 << w[21:20] : 4'h0;
        e_clr = 1'b0;
        for (int c = 0; c < 4; c++) begin
            case (w[27:24])
                4'h0: if (h[c]) begin
                    e_in[c] = w[19:4];
                    if (!ld_n || e_mask[c])
                        e_dac[c] = w[19:4];
                end
                4'h1: if (h[c]) e_dac[c] = e_in[c];
                4'h2, 4'h3: begin
                    if (h[c]) e_in[c] = w[19:4];
                    e_dac[c] = e_in[c];
                end
                4'h4: if (w[c]) e_pd[2*c +: 2] = w[9:8];
                default: ;
            endcase
        end
        case (w[27:24])
            4'h5: if (w[1:0] != 2'h3) e_sel = w[1:0];
            4'h6: e_mask = w[3:0];
            4'h8: {e_ch, e_ref} = w[1:0];
            default: ;
        endcase
    endtask
    task automatic do_clear();
        for (int c = 0; c < 4; c++) begin
            e_in[c] = code(e_sel);
            e_dac[c] = code(e_sel);
        end
        e_clr = 1'b1;
    endtask
    task automatic frame(input logic [31:0] w);
        @(posedge clk_in);
        qdc_host_model_inst.send(w, 32);
        predict(w);
        settle();
        if (e_ch) check(64'(so), 64'(w[31]));
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // hang guard, well beyond the expected run length
    initial begin
        #400_000;
        num_errors++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        void'($urandom(15));
        repeat (6) @(posedge clk_in);
        reset_n_in <= 1'b1;
        settle();
        for (int k = 0; k < 24; k++) begin
            if (k == 8) ld_n <= 1'b1;
            if (k == 16) frame({8'h06, 20'h0_0000, 4'($urandom)});
            frame({6'h00, 2'($urandom),
                   (k % 6 == 5) ? 4'hf : 4'($urandom % 5),
                   16'($urandom), 4'h0});
        end
        ld_n <= 1'b0;
        e_dac = e_in;
        settle();
        ld_n <= 1'b1;
        frame({8'h03, 2'b00, 2'($urandom), 16'($urandom), 4'h0});
        $display("test writes and loads done");
        for (int m = 0; m < 4; m++)
            frame({4'h0, 4'h4, 14'($urandom), 2'(m), 8'($urandom)});
        for (int s = 0; s < 4; s++)
            frame({4'h0, 4'h8, 22'($urandom), 2'(s)});
        $display("test modes and setup done");
        for (int s = 3; s >= 0; s--) begin
            frame({4'($urandom), 4'h5, 22'($urandom),
                   2'(s)});
            clr_n <= 1'b0;
            do_clear();
            settle();
            frame({8'h00, 2'b00, 2'($urandom), 16'($urandom), 4'h0});
            clr_n <= 1'b1;
        end
        $display("test clear codes done");
        qdc_host_model_inst.send({8'h06, 20'hf_ffff, ~e_mask}, 31);
        settle();
        fork
            qdc_host_model_inst.send({8'h06, 20'h0_0000, ~e_mask}, 32);
            begin
                repeat (150) @(posedge clk_in);
                clr_n <= 1'b0;
            end
        join
        do_clear();
        settle();
        $display("test aborts done");
        tally_and_finish();
    end
endmodule
